// ===== pkg/sfsa_consts.svh
// Purpose: constants of the serial frame status and acknowledge logic
// Assumes: included by bare name from the package and the modules
// Notes: definitions only
`ifndef SFSA_CONSTS_SVH
`define SFSA_CONSTS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SFSA_CMD_STATUS_READ 8'h00
`define SFSA_CMD_RW_INC 8'h5A
`define SFSA_CMD_RW_CONT 8'h78
`define SFSA_CMD_SET_IN_PTR 8'h82
`define SFSA_CMD_SET_OUT_PTR 8'h88
`define SFSA_CMD_IN_XFER 8'h90
`define SFSA_CMD_OUT_XFER 8'h9A
`define SFSA_CMD_READ_LO 8'hA0
`define SFSA_CMD_READ_HI 8'hA3
`define SFSA_CMD_HEADER 8'hAA
`define SFSA_CMD_ADDR_PREFIX 6'h28

// ----------------------------------------------------------------
// frame timing, in link clock bits
// ----------------------------------------------------------------
`define SFSA_BYTE_BITS 8'd8
`define SFSA_STATUS_BITS 8'd24
`define SFSA_ACK_START_BIT 8'd40
`define SFSA_STATUS_READ_BITS 8'd48
`define SFSA_BIT_COUNT_MAX 8'hFF

// ----------------------------------------------------------------
// check field and acknowledge
// ----------------------------------------------------------------
`define SFSA_CRC_POLY 16'h1021
`define SFSA_CRC_INIT 16'hFFFF
`define SFSA_CRC_RESIDUE 16'h0000
`define SFSA_ACK_GOOD 8'hFF
`define SFSA_ACK_BAD 8'h00

// ----------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------
`define SFSA_ST0_IN_BUSY 0
`define SFSA_ST0_OUT_BUSY 1
`define SFSA_ST1_CHECK 0
`define SFSA_ST1_SHORT 1
`define SFSA_ST1_LONG 2
`define SFSA_ST1_CC_BUSY 3
`define SFSA_ST1_UNDEF 4
`define SFSA_ST1_FORMAT 6
`define SFSA_ST1_PARITY 7
`define SFSA_ST1_RESET 8'h00
`define SFSA_SNAP_RESET 24'h000000

`endif

// ===== pkg/sfsa_pkg.sv
// Purpose: types and decode helpers of the serial frame status logic
// Assumes: sfsa_consts.svh is on the include path
// Notes: constants live in the header, types here
package sfsa_pkg;
  `include "sfsa_consts.svh"

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
  } sfsa_status_t;

  typedef struct packed {
    logic [7:0] bit_count;
    logic [7:0] command;
    logic check_ok;
  } sfsa_frame_t;

  typedef enum {SFSA_LINK_IDLE, SFSA_LINK_OPEN} sfsa_link_t;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic sfsa_known_cmd(input logic [7:0] cmd);
    sfsa_known_cmd = (cmd == `SFSA_CMD_STATUS_READ) || (cmd == `SFSA_CMD_RW_INC) ||
      (cmd == `SFSA_CMD_RW_CONT) || (cmd == `SFSA_CMD_SET_IN_PTR) ||
      (cmd == `SFSA_CMD_SET_OUT_PTR) || (cmd == `SFSA_CMD_IN_XFER) ||
      (cmd == `SFSA_CMD_OUT_XFER) || (cmd == `SFSA_CMD_READ_LO) ||
      (cmd == `SFSA_CMD_READ_HI) || (cmd == `SFSA_CMD_HEADER);
  endfunction

  // bit 0 carries an address bit in the read commands, so it is exempt there
  function automatic logic sfsa_format_err(input logic [7:0] cmd);
    sfsa_format_err = cmd[2] || (cmd[0] && (cmd[7:2] != `SFSA_CMD_ADDR_PREFIX));
  endfunction
endpackage

// ===== src/sfsa_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: d comes from another clock domain or a pin
// Notes: only the second stage is visible to the user
`timescale 1ns/1ps
module sfsa_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== src/sfsa_crc_step.sv
// Purpose: one bit step of the 16-bit frame check
// Assumes: message bits arrive most significant first
// Notes: purely combinational
`timescale 1ns/1ps
`include "sfsa_consts.svh"
module sfsa_crc_step (
  input wire logic [15:0] crc_in,
  input wire logic bit_in,
  output logic [15:0] crc_out
);
  import sfsa_pkg::*;
  logic feedback;

  assign feedback = crc_in[15] ^ bit_in;
  assign crc_out = {crc_in[14:0], 1'b0} ^ (feedback ? `SFSA_CRC_POLY : 16'h0000);
endmodule

// ===== src/sfsa_top.sv
// Purpose: serial host port frame logic: status prefix, check fields, acknowledge, commit
// Assumes: link mode with clock idle low, device launches on rising and samples on falling
// Assumes: host waits at least 6 system clocks after chip select falls before the first edge
// Notes: frame counters are quasi-static while chip select is high, read there by clk_sys
`timescale 1ns/1ps
`include "sfsa_consts.svh"
module sfsa_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic chip_select_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic in_buf_busy,
  input wire logic out_buf_busy,
  input wire logic [5:0] int_flags,
  input wire logic parity_error_event,
  input wire logic cc_busy,
  input wire logic controller_reset,
  output logic frame_commit,
  output logic frame_abort,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output sfsa_pkg::sfsa_status_t status_snapshot
);
  import sfsa_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sfsa_link_t state_reg;
  logic cs_high_sync;
  logic link_clear_reg;
  logic fall_det;
  logic rise_det;
  sfsa_status_t snap_reg;
  logic [7:0] st1_reg;
  logic [7:0] st1_next;
  logic [7:0] st1_events;
  sfsa_frame_t fin;
  logic is_status_read;
  logic will_act;
  logic commit_reg;
  logic abort_reg;
  logic byte_tog_sync;
  logic byte_tog_prev_reg;
  logic rx_valid_reg;
  logic [7:0] rx_byte_reg;
  logic miso_oe_reg;
  logic [7:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] byte_reg;
  logic byte_tog_reg;
  logic ack_good_reg;
  logic [15:0] crc_rx_reg;
  logic [15:0] crc_rx_next;
  logic [7:0] tx_cnt_reg;
  logic [15:0] crc_tx_reg;
  logic [15:0] crc_tx_next;
  logic tx_bit;
  logic [7:0] ack_byte;
  logic miso_reg;

  // ----------------------------------------------------------------
  // chip select tracking in the system domain
  // ----------------------------------------------------------------
  sfsa_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cs_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(chip_select_n),
    .q(cs_high_sync)
  );

  assign fall_det = (state_reg == SFSA_LINK_IDLE) && !cs_high_sync;
  assign rise_det = (state_reg == SFSA_LINK_OPEN) && cs_high_sync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= SFSA_LINK_IDLE;
    end else begin
      case (state_reg)
        SFSA_LINK_IDLE: if (!cs_high_sync) state_reg <= SFSA_LINK_OPEN;
        SFSA_LINK_OPEN: if (cs_high_sync) state_reg <= SFSA_LINK_IDLE;
        default: state_reg <= SFSA_LINK_IDLE;
      endcase
    end
  end

  // clear rises one clock after the frame was judged, so the judge sees stable counts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link_clear_reg <= 1'b1;
      miso_oe_reg <= 1'b0;
    end else begin
      link_clear_reg <= (state_reg == SFSA_LINK_IDLE) && cs_high_sync;
      miso_oe_reg <= !cs_high_sync;
    end
  end

  // ----------------------------------------------------------------
  // status snapshot
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      snap_reg <= `SFSA_SNAP_RESET;
    end else if (fall_det) begin
      snap_reg.st0 <= 8'h00;
      snap_reg.st0[`SFSA_ST0_OUT_BUSY] <= out_buf_busy;
      snap_reg.st0[`SFSA_ST0_IN_BUSY] <= in_buf_busy;
      snap_reg.st1 <= st1_reg;
      snap_reg.st2 <= {2'b00, int_flags};
    end
  end

  // ----------------------------------------------------------------
  // end of frame judgement
  // ----------------------------------------------------------------
  // link counters are frozen here: no link edge since chip select rose
  assign fin = '{bit_count: rx_cnt_reg, command: cmd_reg, check_ok: ack_good_reg};
  assign is_status_read = (fin.command == `SFSA_CMD_STATUS_READ);
  // exact length means the rise came right after the last acknowledge bit
  assign will_act = is_status_read && fin.check_ok &&
    (fin.bit_count == `SFSA_STATUS_READ_BITS);

  always_comb begin
    st1_events = 8'h00;
    if (rise_det && (fin.bit_count != 8'h00)) begin
      st1_events[`SFSA_ST1_SHORT] = is_status_read &&
        (fin.bit_count < `SFSA_STATUS_READ_BITS);
      st1_events[`SFSA_ST1_LONG] = is_status_read &&
        (fin.bit_count > `SFSA_STATUS_READ_BITS);
      st1_events[`SFSA_ST1_CHECK] = is_status_read && !fin.check_ok &&
        (fin.bit_count >= `SFSA_ACK_START_BIT);
      st1_events[`SFSA_ST1_CC_BUSY] = will_act && cc_busy;
      if (fin.bit_count >= `SFSA_BYTE_BITS) begin
        st1_events[`SFSA_ST1_UNDEF] = !sfsa_known_cmd(fin.command);
        st1_events[`SFSA_ST1_FORMAT] = sfsa_format_err(fin.command);
      end
    end
    st1_events[`SFSA_ST1_PARITY] = parity_error_event;
  end

  // a flag raised in the clearing cycle survives
  assign st1_next = (st1_reg & ~{8{controller_reset}}) | st1_events;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st1_reg <= `SFSA_ST1_RESET;
    end else begin
      st1_reg <= st1_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      commit_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      commit_reg <= rise_det && will_act && !cc_busy;
      abort_reg <= rise_det && (fin.bit_count != 8'h00) && !(will_act && !cc_busy);
    end
  end

  // ----------------------------------------------------------------
  // received bytes, passed on at once
  // ----------------------------------------------------------------
  sfsa_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_tog_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(byte_tog_reg),
    .q(byte_tog_sync)
  );

  // the toggle is forced low by the link clear, so changes then are not bytes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      byte_tog_prev_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
    end else begin
      byte_tog_prev_reg <= byte_tog_sync;
      rx_valid_reg <= (byte_tog_sync != byte_tog_prev_reg) && !link_clear_reg;
      if ((byte_tog_sync != byte_tog_prev_reg) && !link_clear_reg) begin
        rx_byte_reg <= byte_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // link receive side, falling edge
  // ----------------------------------------------------------------
  sfsa_crc_step u_crc_rx (
    .crc_in(crc_rx_reg),
    .bit_in(spi_mosi),
    .crc_out(crc_rx_next)
  );

  always_ff @(negedge spi_sclk or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      rx_cnt_reg <= 8'h00;
      rx_shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      byte_reg <= 8'h00;
      byte_tog_reg <= 1'b0;
      ack_good_reg <= 1'b0;
      crc_rx_reg <= `SFSA_CRC_INIT;
    end else begin
      rx_cnt_reg <= (rx_cnt_reg == `SFSA_BIT_COUNT_MAX) ? rx_cnt_reg : rx_cnt_reg + 8'd1;
      rx_shift_reg <= {rx_shift_reg[6:0], spi_mosi};
      // check runs over the whole host check field: a good one leaves zero
      if (rx_cnt_reg < `SFSA_ACK_START_BIT) begin
        crc_rx_reg <= crc_rx_next;
      end
      if (rx_cnt_reg == `SFSA_ACK_START_BIT - 8'd1) begin
        ack_good_reg <= (crc_rx_next == `SFSA_CRC_RESIDUE);
      end
      if (rx_cnt_reg == `SFSA_BYTE_BITS - 8'd1) begin
        cmd_reg <= {rx_shift_reg[6:0], spi_mosi};
      end else if (rx_cnt_reg[2:0] == 3'h7) begin
        byte_reg <= {rx_shift_reg[6:0], spi_mosi};
        byte_tog_reg <= !byte_tog_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // link transmit side, rising edge
  // ----------------------------------------------------------------
  assign tx_bit = snap_reg[5'd23 - tx_cnt_reg[4:0]];
  assign ack_byte = ack_good_reg ? `SFSA_ACK_GOOD : `SFSA_ACK_BAD;

  sfsa_crc_step u_crc_tx (
    .crc_in(crc_tx_reg),
    .bit_in(tx_bit),
    .crc_out(crc_tx_next)
  );

  always_ff @(posedge spi_sclk or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      tx_cnt_reg <= 8'h00;
      crc_tx_reg <= `SFSA_CRC_INIT;
      miso_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= (tx_cnt_reg == `SFSA_BIT_COUNT_MAX) ? tx_cnt_reg : tx_cnt_reg + 8'd1;
      if (tx_cnt_reg < `SFSA_STATUS_BITS) begin
        miso_reg <= tx_bit;
        crc_tx_reg <= crc_tx_next;
      end else if (tx_cnt_reg < `SFSA_ACK_START_BIT) begin
        miso_reg <= crc_tx_reg[15];
        crc_tx_reg <= {crc_tx_reg[14:0], 1'b0};
      end else if (tx_cnt_reg < `SFSA_STATUS_READ_BITS) begin
        miso_reg <= ack_byte[3'd7 - tx_cnt_reg[2:0]];
      end else begin
        miso_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign spi_miso = miso_reg;
  assign spi_miso_oe = miso_oe_reg;
  assign frame_commit = commit_reg;
  assign frame_abort = abort_reg;
  assign rx_byte_valid = rx_valid_reg;
  assign rx_byte = rx_byte_reg;
  assign status_snapshot = snap_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  st0_reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    snap_reg.st0[7:2] == 6'h00) else $error("status 0 reserved bits not zero");
  st2_reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    snap_reg.st2[7:6] == 2'h0) else $error("status 2 reserved bits not zero");
  snap_on_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fall_det |=> $stable(snap_reg)) else $error("snapshot changed outside cs fall");
  // a select pulse with no link edge counts nothing, so it is left out here
  commit_exact_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_det && (rx_cnt_reg != 8'h00) && (rx_cnt_reg != `SFSA_STATUS_READ_BITS)
    |=> !frame_commit && frame_abort) else $error("commit without exact frame length");
  abort_clocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_det && is_status_read && (rx_cnt_reg > `SFSA_STATUS_READ_BITS)
    |=> !frame_commit && st1_reg[`SFSA_ST1_LONG]) else $error("abort byte not refused");
  good_commit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_det && will_act && !cc_busy |=> frame_commit ##1 !frame_commit)
    else $error("good frame not committed for one cycle");
  check_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_det && is_status_read && (rx_cnt_reg == `SFSA_STATUS_READ_BITS) && !ack_good_reg
    |=> st1_reg[`SFSA_ST1_CHECK] && !frame_commit) else $error("check error not flagged");
  parity_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    parity_error_event |=> st1_reg[`SFSA_ST1_PARITY]) else $error("parity flag missing");
  st1_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !controller_reset |=> (($past(st1_reg) & ~st1_reg) == 8'h00))
    else $error("status 1 flag lost");
  busy_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_det && will_act && cc_busy |=> st1_reg[`SFSA_ST1_CC_BUSY] && !frame_commit)
    else $error("busy error not flagged");
  first_bit_a: assert property (@(posedge spi_sclk) disable iff (link_clear_reg)
    tx_cnt_reg == 8'd1 |-> miso_reg == snap_reg[23]) else $error("status not sent first");
  ack_value_a: assert property (@(posedge spi_sclk) disable iff (link_clear_reg)
    (tx_cnt_reg > `SFSA_ACK_START_BIT) && (tx_cnt_reg <= `SFSA_STATUS_READ_BITS)
    |-> miso_reg == ack_good_reg) else $error("acknowledge bit wrong");

  commit_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n) frame_commit);
  abort_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    frame_abort && st1_reg[`SFSA_ST1_LONG]);
  check_error_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st1_reg[`SFSA_ST1_CHECK]);
  byte_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_byte_valid);
endmodule

// ===== sim/sfsa_host_model.sv
// Purpose: host side serial master model for framed transfers
// Assumes: clock idles low, host launches on rising edge and samples on falling edge
// Notes: link clock runs only inside frames; mosi is inverted once released
`timescale 1ns/1ps
module sfsa_host_model (
  output logic spi_sclk,
  output logic chip_select_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'h0;
    chip_select_n = 1'h1;
    spi_mosi = 1'h0;
  end

  // ----------------------------------------------------------------
  // acknowledge vote
  // ----------------------------------------------------------------
  // majority vote tolerates up to two flipped bits of the acknowledge
  function automatic bit ack_ok(input logic [7:0] a);
    return $countones(a) >= 6;
  endfunction

  // ----------------------------------------------------------------
  // one frame, msb of tx first, 6 ns link period
  // ----------------------------------------------------------------
  task automatic xfer(input logic [55:0] tx, input int nbits, output logic [55:0] rx);
    rx = '0;
    // half a nanosecond keeps every link edge clear of the system clock edges
    #0.5;
    chip_select_n = 1'h0;
    // device needs time to latch its status snapshot before the first edge
    #40;
    // bits past 48 form the abort byte, a framing violation on purpose
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'h1;
      spi_mosi = tx[55-i];
      #3;
      spi_sclk = 1'h0;
      rx[55-i] = spi_miso;
      #3;
    end
    #6;
    chip_select_n = 1'h1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule

// ===== sim/sfsa_top_bench.sv
// Purpose: self-checking bench of the serial frame status and acknowledge logic
// Assumes: host model drives the link, bench drives the system side
// Notes: status 1 flags are read back in the frame after the one that set them
`timescale 1ns/1ps
module sfsa_top_bench;
  import sfsa_pkg::*;

  logic clk_sys, rst_n, spi_sclk, chip_select_n, spi_mosi, spi_miso, spi_miso_oe;
  logic in_buf_busy, out_buf_busy, parity_error_event, cc_busy, controller_reset;
  logic frame_commit, frame_abort, rx_byte_valid;
  logic [5:0] int_flags;
  logic [7:0] rx_byte, rx_last;
  sfsa_status_t status_snapshot;
  int err_total, cmp_count, n_commit, n_abort, rx_n;
  logic [7:0] t_cmd [7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h04, 8'hA3, 8'h00};
  int t_bits [7] = '{48, 56, 32, 48, 48, 48, 48};
  logic [7:0] t_st1 [7] = '{8'h01, 8'h04, 8'h02, 8'h10, 8'h50, 8'h00, 8'h08};

  sfsa_top sfsa_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .chip_select_n(chip_select_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .in_buf_busy(in_buf_busy), .out_buf_busy(out_buf_busy),
    .int_flags(int_flags), .parity_error_event(parity_error_event), .cc_busy(cc_busy),
    .controller_reset(controller_reset), .frame_commit(frame_commit),
    .frame_abort(frame_abort), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .status_snapshot(status_snapshot));
  sfsa_host_model sfsa_host_model_inst (.spi_sclk(spi_sclk), .chip_select_n(chip_select_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  // ----------------------------------------------------------------
  // clock and monitors
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (frame_commit === 1'h1) n_commit++;
    if (frame_abort === 1'h1) n_abort++;
    if (rx_byte_valid === 1'h1) begin
      rx_n++;
      rx_last = rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [23:0] d);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 23; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'h0} ^ 16'h1021) : {c[14:0], 1'h0};
    end
    return c;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one frame, then a bounded wait for its commit or abort pulse
  task automatic frame(input logic [7:0] cmd, input int nbits, input bit bad,
    output logic [55:0] rx);
    logic [15:0] c;
    c = crc16({cmd, 16'h0000}) ^ {15'h0000, bad};
    n_commit = 0;
    n_abort = 0;
    rx_n = 0;
    sfsa_host_model_inst.xfer({cmd, 16'h0000, c, 8'h5C, 8'hAB}, nbits, rx);
    for (int k = 0; k < 40 && n_commit + n_abort == 0; k++) @(posedge clk_sys);
    // keeps chip select high long enough between frames
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic st_read(input logic [23:0] exp);
    logic [55:0] rx;
    frame(8'h00, 48, 1'b0, rx);
    chk(rx[55:8], {exp, crc16(exp), 8'hFF}, "status frame");
    chk(48'(sfsa_host_model_inst.ack_ok(rx[15:8])), 48'h1, "ack vote");
    chk(48'(n_commit), 48'h1, "commit count");
    chk(48'(status_snapshot), 48'(exp), "snapshot");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main_seq
    logic [55:0] rx;
    rst_n = 1'h0;
    in_buf_busy = 1'h0;
    out_buf_busy = 1'h0;
    int_flags = 6'h00;
    parity_error_event = 1'h0;
    cc_busy = 1'h0;
    controller_reset = 1'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk({21'h0, spi_miso_oe, frame_commit, frame_abort, status_snapshot}, 48'h0, "reset");
    $display("test reset done");

    in_buf_busy <= 1'h1;
    int_flags <= 6'h2A;
    @(posedge clk_sys);
    fork
      st_read(24'h01002A);
      begin
        #150;
        @(posedge clk_sys);
        out_buf_busy <= 1'h1;
        chk({47'h0, spi_miso_oe}, 48'h1, "miso enable in frame");
      end
    join
    st_read(24'h03002A);
    chk({40'h0, rx_last}, 48'h5C, "last rx byte");
    chk(48'(rx_n), 48'h5, "rx byte count");
    in_buf_busy <= 1'h0;
    out_buf_busy <= 1'h0;
    int_flags <= 6'h00;
    @(posedge clk_sys);
    $display("test status prefix done");

    // bad check, long, short, undefined, format, exempt read, controller busy
    for (int r = 0; r < 8; r++) begin
      if (r < 7) begin
        cc_busy <= (r == 6);
        frame(t_cmd[r], t_bits[r], r == 0, rx);
        cc_busy <= 1'h0;
        chk(48'(n_commit), 48'h0, "suppressed");
        chk(48'(n_abort), 48'h1, "abort pulse");
        if (t_bits[r] >= 48 && t_cmd[r] == 8'h00) begin
          chk(48'(rx[15:8]), (r == 0) ? 48'h00 : 48'hFF, "ack");
          chk(48'(sfsa_host_model_inst.ack_ok(rx[15:8])), (r == 0) ? 48'h0 : 48'h1, "vote");
        end
        repeat (2) st_read({8'h00, t_st1[r], 8'h00});
      end else begin
        parity_error_event <= 1'h1;
        @(posedge clk_sys);
        parity_error_event <= 1'h0;
        st_read(24'h008000);
      end
      @(posedge clk_sys);
      controller_reset <= 1'h1;
      @(posedge clk_sys);
      controller_reset <= 1'h0;
      @(posedge clk_sys);
      st_read(24'h000000);
    end
    $display("test session flags done");
    test_done();
  end

  initial begin
    #100000;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end
endmodule
